/* shared/safe_direction_monitor_defines.svh */
// Offsets, field positions, reset values and timing counts of the direction monitor
`ifndef SAFE_DIRECTION_MONITOR_DEFINES_SVH
`define SAFE_DIRECTION_MONITOR_DEFINES_SVH

// Register byte offsets
`define OFS_CONFIG 8'h00
`define OFS_SOURCE 8'h04
`define OFS_POS_WINDOW 8'h08
`define OFS_VEL_WINDOW 8'h0C
`define OFS_POS_DELAY 8'h10
`define OFS_NEG_DELAY 8'h14
`define OFS_REACTION 8'h18
`define OFS_STATUS 8'h1C
`define OFS_IRQ_STATUS 8'h20
`define OFS_IRQ_MASK 8'h24
`define OFS_POS_REF 8'h28
`define OFS_NEG_REF 8'h2C

// Config fields
`define CFG_ENABLE_BIT 0
`define CFG_CLEAR_BIT 1

// Source select fields: input index plus one, zero means not used
`define SRC_POS_SEL_LSB 0
`define SRC_POS_FSOE_BIT 4
`define SRC_NEG_SEL_LSB 8
`define SRC_NEG_FSOE_BIT 12
`define SRC_SEL_W 4

// Status fields
`define STS_POS_MOVING_BIT 0
`define STS_NEG_MOVING_BIT 1
`define STS_FAULT_BIT 2
`define STS_POS_STATE_LSB 4
`define STS_NEG_STATE_LSB 8

// Interrupt bits
`define IRQ_VIOLATION_BIT 0
`define IRQ_POS_ARMED_BIT 1
`define IRQ_NEG_ARMED_BIT 2
`define IRQ_W 3

// Reset values
`define RST_POS_WINDOW 32'h0000_0001
`define RST_VEL_WINDOW 32'h0000_0001
`define RST_DELAY_MS 16'h0001
`define RST_SOURCE 32'h0000_0000
`define RST_REACTION 2'h1

// Timing
`define CLK_HZ 10000000
`define DELAY_UNIT_MS 1
`define TICK_CYCLES ((`CLK_HZ / 1000) * `DELAY_UNIT_MS)

`endif

/* shared/safe_direction_monitor_pkg.sv */
// Types shared by the direction monitor and its guards
package safe_direction_monitor_pkg;

   // Internal state of one direction guard
   typedef enum logic [2:0] {
      GUARD_IDLE = 3'b000,
      GUARD_WAIT = 3'b001,
      GUARD_MONITOR = 3'b010,
      GUARD_FAILED = 3'b100
   } guard_internal_state_t;

   // Selected fault reaction
   typedef enum logic [1:0] {
      SAFE_TORQUE_OFF_REACTION = 2'b01,
      STOP_ONE_REACTION = 2'b10,
      STOP_TWO_REACTION = 2'b11
   } fault_reaction_t;

endpackage

/* src/pin_sync.sv */
// Three-stage input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] pin,
   output logic [WIDTH-1:0] level
);
   logic [WIDTH-1:0] s1_q; // First stage, read only by the second
   logic [WIDTH-1:0] s2_q; // Second stage
   logic [WIDTH-1:0] s3_q; // Third stage

   // Shift chain
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Accept only bits where the last two stages agree
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         level <= '0;
      end else begin
         level <= (s2_q & s3_q) | (level & (s2_q | s3_q));
      end
   end
endmodule
`default_nettype wire

/* src/direction_guard.sv */
// One direction guard: activation, start delay, reference capture and window check
`timescale 1ns/1ns
`default_nettype none
module direction_guard
   import safe_direction_monitor_pkg::*;
#(
   parameter int POS_W = 32,
   parameter int VEL_W = 32,
   parameter int DLY_W = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic request,
   input wire logic tick,
   input wire logic fault,
   input wire logic clear,
   input wire logic neg_dir,
   input wire logic signed [POS_W-1:0] position,
   input wire logic signed [VEL_W-1:0] velocity,
   input wire logic [POS_W-1:0] pos_win,
   input wire logic [VEL_W-1:0] vel_win,
   input wire logic [DLY_W-1:0] delay,
   output guard_internal_state_t state,
   output logic violation,
   output logic armed,
   output logic signed [POS_W-1:0] ref_pos
);
   logic [DLY_W:0] cnt_q; // Elapsed delay ticks, saturating
   logic expired; // Start delay has run out
   logic signed [POS_W+1:0] p_ext; // Position widened
   logic signed [POS_W+1:0] r_ext; // Reference widened
   logic signed [POS_W+1:0] w_ext; // Window widened
   logic signed [VEL_W+1:0] v_ext; // Velocity widened
   logic signed [VEL_W+1:0] vw_ext; // Velocity window widened
   logic outside; // Motion in the forbidden direction

   // A tick may fall anywhere in the first unit, so count one unit more
   assign expired = (delay == '0) || (cnt_q > {1'b0, delay});

   assign p_ext = {{2{position[POS_W-1]}}, position};
   assign r_ext = {{2{ref_pos[POS_W-1]}}, ref_pos};
   assign w_ext = {2'b00, pos_win};
   assign v_ext = {{2{velocity[VEL_W-1]}}, velocity};
   assign vw_ext = {2'b00, vel_win};

   // Forbidden-direction test against captured window and velocity window
   always_comb begin
      if (neg_dir) begin
         outside = (p_ext < r_ext - w_ext) || (v_ext < -vw_ext);
      end else begin
         outside = (p_ext > r_ext + w_ext) || (v_ext > vw_ext);
      end
   end

   assign violation = (state == GUARD_MONITOR) && outside;
   assign armed = (state == GUARD_WAIT) && request && expired && !fault;

   // Guard state machine
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= GUARD_IDLE;
      end else if (fault && !clear) begin // Clear comes while the latch still reads high
         state <= GUARD_FAILED;
      end else begin
         case (state)
            GUARD_IDLE: begin
               if (request) begin
                  state <= GUARD_WAIT;
               end
            end
            GUARD_WAIT: begin
               if (!request) begin
                  state <= GUARD_IDLE;
               end else if (expired) begin
                  state <= GUARD_MONITOR;
               end
            end
            GUARD_MONITOR: begin
               if (!request) begin
                  state <= GUARD_IDLE;
               end
            end
            GUARD_FAILED: begin
               if (clear) begin
                  state <= GUARD_IDLE;
               end
            end
            default: begin
               state <= GUARD_IDLE;
            end
         endcase
      end
   end

   // Delay counter restarts on every activation
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
      end else if (state != GUARD_WAIT) begin
         cnt_q <= '0;
      end else if (tick && !(&cnt_q)) begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   // Reference position taken at the moment of activation
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ref_pos <= '0;
      end else if (state == GUARD_IDLE && request && !fault) begin
         ref_pos <= position;
      end
   end
endmodule
`default_nettype wire

/* src/safe_direction_monitor.sv */
// Safe direction monitor top: APB registers, activation, motion flags and fault reaction
`include "safe_direction_monitor_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module safe_direction_monitor
   import safe_direction_monitor_pkg::*;
#(
   parameter int POS_W = 32,
   parameter int VEL_W = 32,
   parameter int DLY_W = 16,
   parameter int N_SAFE_IN = 8,
   parameter int TICK_CYCLES = `TICK_CYCLES
) (
   input wire logic SYS_CLK,
   input wire logic RSTN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [N_SAFE_IN-1:0] SAFE_IN,
   input wire logic FSOE_POS_REQ,
   input wire logic FSOE_NEG_REQ,
   input wire logic signed [POS_W-1:0] SAFE_POSITION,
   input wire logic signed [VEL_W-1:0] SAFE_VELOCITY,
   output logic POS_MOTION_FLAG,
   output logic NEG_MOTION_FLAG,
   output logic FAULT_ACTIVATE,
   output logic [1:0] FAULT_REACTION,
   output logic IRQ
);
   localparam int SYNC_W = N_SAFE_IN + 2;
   localparam int TICK_W = $clog2(TICK_CYCLES + 1);

   // Register state
   logic enable_q; // Function activation
   logic [31:0] source_q; // Activation source selection
   logic [POS_W-1:0] pos_win_q; // Shared position zero window
   logic [VEL_W-1:0] vel_win_q; // Shared velocity zero window
   logic [DLY_W-1:0] pos_dly_q; // Positive guard start delay
   logic [DLY_W-1:0] neg_dly_q; // Negative guard start delay
   logic [1:0] reaction_q; // Selected fault reaction
   logic [`IRQ_W-1:0] irq_sts_q; // Sticky events
   logic [`IRQ_W-1:0] irq_mask_q; // Event enables
   logic fault_q; // Fault reaction latched
   logic clear_pulse; // Software fault clear

   // Bus decode
   logic setup; // APB setup phase
   logic wr_en; // APB write access phase
   logic mapped; // Address hits a register
   logic [31:0] rd_d; // Read mux

   // Synchronised activation inputs
   logic [SYNC_W-1:0] sync_level;
   logic [N_SAFE_IN-1:0] safe_in_s;
   logic fsoe_pos_s;
   logic fsoe_neg_s;
   logic pos_req; // Positive guard activation request
   logic neg_req; // Negative guard activation request

   // Delay tick divider
   logic [TICK_W-1:0] div_q;
   logic tick;

   // Guard outputs
   guard_internal_state_t pos_state;
   guard_internal_state_t neg_state;
   logic pos_viol;
   logic neg_viol;
   logic pos_armed;
   logic neg_armed;
   logic signed [POS_W-1:0] pos_ref;
   logic signed [POS_W-1:0] neg_ref;
   logic [`IRQ_W-1:0] irq_set; // Event pulses this cycle

   // Motion detection operands
   logic signed [VEL_W+1:0] v_ext;
   logic signed [VEL_W+1:0] vw_ext;

   // Activation pins come from outside this clock domain
   pin_sync #(
      .WIDTH(SYNC_W)
   ) u_sync (
      .clk(SYS_CLK),
      .rst_n(RSTN),
      .pin({FSOE_NEG_REQ, FSOE_POS_REQ, SAFE_IN}),
      .level(sync_level)
   );

   assign safe_in_s = sync_level[N_SAFE_IN-1:0];
   assign fsoe_pos_s = sync_level[N_SAFE_IN];
   assign fsoe_neg_s = sync_level[N_SAFE_IN+1];

   // Pick the mapped safe input for a selector value; zero means not used
   function automatic logic pick_input(input logic [`SRC_SEL_W-1:0] sel,
                                       input logic [N_SAFE_IN-1:0] pins);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < N_SAFE_IN; i++) begin
         if (int'(sel) == i + 1) begin
            hit = pins[i];
         end
      end
      return hit;
   endfunction

   // Activation requests, each guard with its own source
   always_comb begin
      pos_req = enable_q &&
         (pick_input(source_q[`SRC_POS_SEL_LSB +: `SRC_SEL_W], safe_in_s) ||
          (source_q[`SRC_POS_FSOE_BIT] && fsoe_pos_s));
      neg_req = enable_q &&
         (pick_input(source_q[`SRC_NEG_SEL_LSB +: `SRC_SEL_W], safe_in_s) ||
          (source_q[`SRC_NEG_FSOE_BIT] && fsoe_neg_s));
   end

   // Free-running divider giving one delay-unit tick
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         div_q <= '0;
      end else if (div_q == TICK_W'(TICK_CYCLES - 1)) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 1'b1;
      end
   end

   assign tick = (div_q == TICK_W'(TICK_CYCLES - 1));

   // Positive direction guard, sharing windows with the negative one
   direction_guard #(
      .POS_W(POS_W),
      .VEL_W(VEL_W),
      .DLY_W(DLY_W)
   ) u_pos_guard (
      .clk(SYS_CLK),
      .rst_n(RSTN),
      .request(pos_req),
      .tick(tick),
      .fault(fault_q),
      .clear(clear_pulse),
      .neg_dir(1'b0),
      .position(SAFE_POSITION),
      .velocity(SAFE_VELOCITY),
      .pos_win(pos_win_q),
      .vel_win(vel_win_q),
      .delay(pos_dly_q),
      .state(pos_state),
      .violation(pos_viol),
      .armed(pos_armed),
      .ref_pos(pos_ref)
   );

   // Negative direction guard; with both monitoring only standstill passes
   direction_guard #(
      .POS_W(POS_W),
      .VEL_W(VEL_W),
      .DLY_W(DLY_W)
   ) u_neg_guard (
      .clk(SYS_CLK),
      .rst_n(RSTN),
      .request(neg_req),
      .tick(tick),
      .fault(fault_q),
      .clear(clear_pulse),
      .neg_dir(1'b1),
      .position(SAFE_POSITION),
      .velocity(SAFE_VELOCITY),
      .pos_win(pos_win_q),
      .vel_win(vel_win_q),
      .delay(neg_dly_q),
      .state(neg_state),
      .violation(neg_viol),
      .armed(neg_armed),
      .ref_pos(neg_ref)
   );

   // Fault latch; a new violation wins over a software clear
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         fault_q <= 1'b0;
      end else if (pos_viol || neg_viol) begin
         fault_q <= 1'b1;
      end else if (clear_pulse) begin
         fault_q <= 1'b0;
      end
   end

   // Fault outputs; an unknown reaction code falls back to torque off
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         FAULT_ACTIVATE <= 1'b0;
         FAULT_REACTION <= `RST_REACTION;
      end else begin
         FAULT_ACTIVATE <= fault_q;
         if (reaction_q == STOP_ONE_REACTION || reaction_q == STOP_TWO_REACTION) begin
            FAULT_REACTION <= reaction_q;
         end else begin
            FAULT_REACTION <= SAFE_TORQUE_OFF_REACTION;
         end
      end
   end

   // Motion flags against the shared velocity zero window
   assign v_ext = {{2{SAFE_VELOCITY[VEL_W-1]}}, SAFE_VELOCITY};
   assign vw_ext = {2'b00, vel_win_q};

   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         POS_MOTION_FLAG <= 1'b0;
         NEG_MOTION_FLAG <= 1'b0;
      end else begin
         POS_MOTION_FLAG <= (v_ext > vw_ext);
         NEG_MOTION_FLAG <= (v_ext < -vw_ext);
      end
   end

   // APB decode: zero wait states, error on unmapped addresses
   assign setup = PSEL && !PENABLE;
   assign wr_en = PSEL && PENABLE && PWRITE && mapped;
   assign PREADY = 1'b1;
   assign clear_pulse = wr_en && (PADDR == `OFS_CONFIG) && PWDATA[`CFG_CLEAR_BIT];

   always_comb begin
      mapped = 1'b1;
      rd_d = 32'h0000_0000;
      if (PADDR == `OFS_CONFIG) begin
         rd_d[`CFG_ENABLE_BIT] = enable_q;
      end else if (PADDR == `OFS_SOURCE) begin
         rd_d = source_q;
      end else if (PADDR == `OFS_POS_WINDOW) begin
         rd_d = 32'(pos_win_q);
      end else if (PADDR == `OFS_VEL_WINDOW) begin
         rd_d = 32'(vel_win_q);
      end else if (PADDR == `OFS_POS_DELAY) begin
         rd_d = 32'(pos_dly_q);
      end else if (PADDR == `OFS_NEG_DELAY) begin
         rd_d = 32'(neg_dly_q);
      end else if (PADDR == `OFS_REACTION) begin
         rd_d[1:0] = reaction_q;
      end else if (PADDR == `OFS_STATUS) begin
         rd_d[`STS_POS_MOVING_BIT] = POS_MOTION_FLAG;
         rd_d[`STS_NEG_MOVING_BIT] = NEG_MOTION_FLAG;
         rd_d[`STS_FAULT_BIT] = fault_q;
         rd_d[`STS_POS_STATE_LSB +: 3] = pos_state;
         rd_d[`STS_NEG_STATE_LSB +: 3] = neg_state;
      end else if (PADDR == `OFS_IRQ_STATUS) begin
         rd_d[`IRQ_W-1:0] = irq_sts_q;
      end else if (PADDR == `OFS_IRQ_MASK) begin
         rd_d[`IRQ_W-1:0] = irq_mask_q;
      end else if (PADDR == `OFS_POS_REF) begin
         rd_d = 32'(pos_ref);
      end else if (PADDR == `OFS_NEG_REF) begin
         rd_d = 32'(neg_ref);
      end else begin
         mapped = 1'b0;
      end
   end

   assign PSLVERR = PSEL && PENABLE && !mapped;

   // Read data is captured in the setup phase and held through the access
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         PRDATA <= 32'h0000_0000;
      end else if (setup && !PWRITE) begin
         PRDATA <= rd_d;
      end
   end

   // Configuration registers
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         enable_q <= 1'b0;
         source_q <= `RST_SOURCE;
         pos_win_q <= POS_W'(`RST_POS_WINDOW);
         vel_win_q <= VEL_W'(`RST_VEL_WINDOW);
         pos_dly_q <= DLY_W'(`RST_DELAY_MS);
         neg_dly_q <= DLY_W'(`RST_DELAY_MS);
         reaction_q <= `RST_REACTION;
         irq_mask_q <= '0;
      end else if (wr_en) begin
         if (PADDR == `OFS_CONFIG) begin
            enable_q <= PWDATA[`CFG_ENABLE_BIT];
         end else if (PADDR == `OFS_SOURCE) begin
            source_q <= PWDATA;
         end else if (PADDR == `OFS_POS_WINDOW) begin
            pos_win_q <= PWDATA[POS_W-1:0];
         end else if (PADDR == `OFS_VEL_WINDOW) begin
            vel_win_q <= PWDATA[VEL_W-1:0];
         end else if (PADDR == `OFS_POS_DELAY) begin
            pos_dly_q <= PWDATA[DLY_W-1:0];
         end else if (PADDR == `OFS_NEG_DELAY) begin
            neg_dly_q <= PWDATA[DLY_W-1:0];
         end else if (PADDR == `OFS_REACTION) begin
            reaction_q <= PWDATA[1:0];
         end else if (PADDR == `OFS_IRQ_MASK) begin
            irq_mask_q <= PWDATA[`IRQ_W-1:0];
         end
      end
   end

   // Sticky events, write one to clear; a new event wins over the clear
   always_comb begin
      irq_set = '0;
      irq_set[`IRQ_VIOLATION_BIT] = (pos_viol || neg_viol) && !fault_q;
      irq_set[`IRQ_POS_ARMED_BIT] = pos_armed;
      irq_set[`IRQ_NEG_ARMED_BIT] = neg_armed;
   end

   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         irq_sts_q <= '0;
      end else if (wr_en && PADDR == `OFS_IRQ_STATUS) begin
         irq_sts_q <= (irq_sts_q & ~PWDATA[`IRQ_W-1:0]) | irq_set;
      end else begin
         irq_sts_q <= irq_sts_q | irq_set;
      end
   end

   // Level interrupt while any unmasked event is pending
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= |(irq_sts_q & irq_mask_q);
      end
   end
endmodule
`default_nettype wire

/* tb/safe_direction_monitor_monitor.sv */
// Port checker of the direction monitor, bound to its top module
`include "safe_direction_monitor_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module safe_direction_monitor_monitor #(
   parameter int VEL_W = 32
) (
   input wire logic SYS_CLK,
   input wire logic RSTN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic signed [VEL_W-1:0] SAFE_VELOCITY,
   input wire logic POS_MOTION_FLAG,
   input wire logic NEG_MOTION_FLAG,
   input wire logic FAULT_ACTIVATE,
   input wire logic [1:0] FAULT_REACTION,
   input wire logic IRQ
);
   logic wr;
   logic clr;
   logic [31:0] vwin_q;
   logic [2:0] mask_q;
   // Completed write and fault clear strobes
   assign wr = PSEL && PENABLE && PWRITE;
   assign clr = wr && PADDR == `OFS_CONFIG && PWDATA[`CFG_CLEAR_BIT];
   // Mirror of velocity window and interrupt mask
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         vwin_q <= 32'h0000_0001;
         mask_q <= 3'h0;
      end else if (wr) begin
         if (PADDR == `OFS_VEL_WINDOW) vwin_q <= PWDATA;
         if (PADDR == `OFS_IRQ_MASK) mask_q <= PWDATA[2:0];
      end
   end
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RSTN);
   ready_zero_wait_a: assert property (PSEL && PENABLE |-> PREADY)
      else $error("access phase without ready");
   err_unmapped_a: assert property (PSEL && PENABLE |->
      PSLVERR == (PADDR > `OFS_NEG_REF || PADDR[1:0] != 2'h0))
      else $error("slave error does not match address map");
   pos_flag_level_a: assert property ($past(RSTN) |-> POS_MOTION_FLAG ==
      ($past(SAFE_VELOCITY) > $signed({1'b0, $past(vwin_q)})))
      else $error("positive motion flag wrong");
   neg_flag_level_a: assert property ($past(RSTN) |-> NEG_MOTION_FLAG ==
      ($past(SAFE_VELOCITY) < -$signed({1'b0, $past(vwin_q)})))
      else $error("negative motion flag wrong");
   fault_holds_a: assert property (
      FAULT_ACTIVATE && !clr && !$past(clr) |=> FAULT_ACTIVATE)
      else $error("fault dropped without clear");
   fault_irq_a: assert property ($rose(FAULT_ACTIVATE) && mask_q[0] |-> IRQ)
      else $error("unmasked fault gave no interrupt");
   mask_quiet_a: assert property ($past(mask_q) == 3'h0 |-> !IRQ)
      else $error("interrupt while fully masked");
   reaction_follow_a: assert property (wr && PADDR == `OFS_REACTION |-> ##2
      FAULT_REACTION == (($past(PWDATA[1:0], 2) == 2'h0) ? 2'h1 : $past(PWDATA[1:0], 2)))
      else $error("reaction output does not follow register");
   // Main scenarios reached
   cover property ($rose(FAULT_ACTIVATE));
   cover property (POS_MOTION_FLAG);
   cover property (NEG_MOTION_FLAG);
   cover property (PSEL && PENABLE && PSLVERR);
endmodule
bind safe_direction_monitor safe_direction_monitor_monitor #(.VEL_W(VEL_W)) u_monitor (
   .SYS_CLK(SYS_CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
   .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .SAFE_VELOCITY(SAFE_VELOCITY), .POS_MOTION_FLAG(POS_MOTION_FLAG),
   .NEG_MOTION_FLAG(NEG_MOTION_FLAG), .FAULT_ACTIVATE(FAULT_ACTIVATE),
   .FAULT_REACTION(FAULT_REACTION), .IRQ(IRQ));
`default_nettype wire

/* tb/feedback_model.sv */
// Safe feedback model: registered velocity word and integrated position
`timescale 1ns/1ns
`default_nettype none
module feedback_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic signed [31:0] vel_cmd,
   output logic signed [31:0] position,
   output logic signed [31:0] velocity
);
   // Position advances by the velocity each cycle, as an encoder would
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         position <= 32'sh0000_1000;
         velocity <= 32'sh0000_0000;
      end else begin
         velocity <= vel_cmd;
         position <= position + velocity;
      end
   end
endmodule
`default_nettype wire

/* tb/safe_direction_monitor_tb.sv */
// Self-checking bench of the direction monitor over APB and feedback ports
`include "safe_direction_monitor_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module safe_direction_monitor_tb;
   localparam int TICK = 10;
   logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00, safe_in = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata;
   logic fsoe_pos = 1'b0, fsoe_neg = 1'b0;
   logic signed [31:0] vel_cmd = 32'sh0000_0000, position, velocity;
   logic pready, pslverr, pos_flag, neg_flag, fault, irq;
   logic [1:0] reaction;
   int fail_count = 0, n_checks = 0, cyc = 0;
   // Clock of 100 ns
   initial forever #50 clk = ~clk;
   safe_direction_monitor #(.TICK_CYCLES(TICK)) u_safe_direction_monitor (.SYS_CLK(clk),
      .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .SAFE_IN(safe_in), .FSOE_POS_REQ(fsoe_pos), .FSOE_NEG_REQ(fsoe_neg),
      .SAFE_POSITION(position), .SAFE_VELOCITY(velocity), .POS_MOTION_FLAG(pos_flag),
      .NEG_MOTION_FLAG(neg_flag), .FAULT_ACTIVATE(fault), .FAULT_REACTION(reaction),
      .IRQ(irq));
   feedback_model u_feedback_model (.clk(clk), .rst_n(rstn), .vel_cmd(vel_cmd),
      .position(position), .velocity(velocity));
   // Verdict and end of run
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Cycle count with a hang ceiling
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         fail_count++;
         report_and_stop();
      end
   end
   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
      end
   endtask
   // One APB transfer; request held until ready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] x, input string n);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0000_0000, q, e);
      chk(n, q, x);
   endtask
   // Poll one guard state field of the status register
   task automatic wait_state(input int lsb, input logic [2:0] s);
      logic [31:0] q;
      logic e;
      do apb(1'b0, `OFS_STATUS, 32'h0000_0000, q, e); while (q[lsb+:3] !== s);
   endtask
   // Stop motion, then clear interrupts and the latched fault
   task automatic clear_fault();
      vel_cmd <= 32'sh0000_0000;
      repeat (4) @(posedge clk);
      wr(`OFS_IRQ_STATUS, 32'h0000_0007);
      wr(`OFS_CONFIG, 32'h0000_0003);
      repeat (2) @(posedge clk);
      chk("fault cleared", 32'(fault), 32'h0);
      chk("irq cleared", 32'(irq), 32'h0);
   endtask
   initial begin : main
      logic [31:0] q;
      logic e;
      int t0;
      logic signed [31:0] vt [5] = '{32'sd2, 32'sd1, 32'sd0, -32'sd1, -32'sd2};
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      rdc(`OFS_POS_WINDOW, 32'h0000_0001, "position window");
      rdc(`OFS_VEL_WINDOW, 32'h0000_0001, "velocity window");
      rdc(`OFS_POS_DELAY, 32'h0000_0001, "positive delay");
      rdc(`OFS_NEG_DELAY, 32'h0000_0001, "negative delay");
      rdc(`OFS_REACTION, 32'h0000_0001, "reaction");
      rdc(`OFS_SOURCE, 32'h0000_0000, "source");
      apb(1'b0, 8'h30, 32'h0000_0000, q, e);
      chk("unmapped error", 32'(e), 32'h1);
      $display("test reset values done");
      // Flags against the shared velocity window of 1
      foreach (vt[i]) begin
         vel_cmd <= vt[i];
         repeat (3) @(posedge clk);
         chk("flags", {30'h0, pos_flag, neg_flag}, {30'h0, vt[i] > 1, vt[i] < -1});
      end
      vel_cmd <= 32'sh0000_0000;
      for (int c = 0; c < 4; c++) begin
         wr(`OFS_REACTION, 32'(c));
         @(posedge clk);
         chk("reaction out", 32'(reaction), (c == 0) ? 32'h1 : 32'(c));
      end
      $display("test flags and reactions done");
      wr(`OFS_IRQ_MASK, 32'h0000_0007);
      wr(`OFS_POS_DELAY, 32'h0000_0002);
      wr(`OFS_SOURCE, 32'h0000_0001);
      wr(`OFS_CONFIG, 32'h0000_0001);
      safe_in <= 8'h01;
      t0 = cyc;
      wait_state(`STS_POS_STATE_LSB, 3'h1);
      rdc(`OFS_POS_REF, position, "captured reference");
      vel_cmd <= 32'sh0000_0005;
      while (fault !== 1'b1) @(posedge clk);
      chk("delay", 32'(cyc - t0 >= 2 * TICK && cyc - t0 <= 3 * TICK + 10), 32'h1);
      rdc(`OFS_STATUS, 32'h0000_0445, "failed states");
      chk("irq raised", 32'(irq), 32'h1);
      rdc(`OFS_IRQ_STATUS, 32'h0000_0003, "irq status");
      safe_in <= 8'h00;
      clear_fault();
      $display("test positive guard done");
      wr(`OFS_NEG_DELAY, 32'h0000_0000);
      wr(`OFS_SOURCE, 32'h0000_1000);
      fsoe_neg <= 1'b1;
      wait_state(`STS_NEG_STATE_LSB, 3'h2);
      apb(1'b0, `OFS_NEG_REF, 32'h0000_0000, q, e);
      vel_cmd <= 32'sh0000_0005;
      repeat (10) @(posedge clk);
      chk("positive motion allowed", 32'(fault), 32'h0);
      vel_cmd <= -32'sh0000_0001;
      while (fault !== 1'b1) @(posedge clk);
      chk("window edge", 32'(position <= $signed(q) - 2 &&
         position >= $signed(q) - 6), 32'h1);
      fsoe_neg <= 1'b0;
      clear_fault();
      $display("test negative guard done");
      wr(`OFS_IRQ_MASK, 32'h0000_0000);
      wr(`OFS_POS_DELAY, 32'h0000_0000);
      wr(`OFS_SOURCE, 32'h0000_1010);
      for (int i = 0; i < 2; i++) begin
         fsoe_pos <= 1'b1;
         fsoe_neg <= 1'b1;
         wait_state(`STS_POS_STATE_LSB, 3'h2);
         wait_state(`STS_NEG_STATE_LSB, 3'h2);
         repeat (10) @(posedge clk);
         chk("standstill allowed", 32'(fault), 32'h0);
         vel_cmd <= (i == 0) ? 32'sh0000_0002 : -32'sh0000_0002;
         repeat (6) @(posedge clk);
         chk("motion refused", 32'(fault), 32'h1);
         chk("masked irq", 32'(irq), 32'h0);
         fsoe_pos <= 1'b0;
         fsoe_neg <= 1'b0;
         clear_fault();
      end
      $display("test both guards done");
      report_and_stop();
   end
endmodule
`default_nettype wire
